// ==== core/line_mux_defs.vh ====
`ifndef LINE_MUX_DEFS_VH
`define LINE_MUX_DEFS_VH

// ----------------------------------------------------------------
// register offsets (byte addresses)
// ----------------------------------------------------------------
`define OFS_OWNER_ENABLE     8'h00
`define OFS_OWNER_DISABLE    8'h04
`define OFS_OWNER_STATUS     8'h08
`define OFS_DRIVE_ENABLE     8'h10
`define OFS_DRIVE_DISABLE    8'h14
`define OFS_DRIVE_STATUS     8'h18
`define OFS_FILTER_ENABLE    8'h20
`define OFS_FILTER_DISABLE   8'h24
`define OFS_FILTER_STATUS    8'h28
`define OFS_OUT_SET          8'h30
`define OFS_OUT_CLEAR        8'h34
`define OFS_OUT_STATUS       8'h38
`define OFS_PIN_SAMPLE       8'h3C
`define OFS_IRQ_ENABLE       8'h40
`define OFS_IRQ_DISABLE      8'h44
`define OFS_IRQ_MASK         8'h48
`define OFS_IRQ_STATUS       8'h4C
// reserved words in the map
`define OFS_RESV_0           8'h0C
`define OFS_RESV_1           8'h1C
`define OFS_RESV_2           8'h2C

// ----------------------------------------------------------------
// reset values and line maps
// ----------------------------------------------------------------
`define RST_OWNER            32'h01FFFFFF
`define RST_ZERO             32'h00000000
// lines 16..19, 23, 24 carry no peripheral function
`define LINES_NO_PERIPH      32'h018F0000
// glitch filter: level must hold this many cycles plus one before it passes, unless it reverses a level passed on the previous sample
`define FILTER_CYCLES        2'h2

`endif

// ==== core/parallel_io_mux_controller.v ====
// Our own choice: the plain strobed port.
`timescale 1ns/1ps
`include "line_mux_defs.vh"

// Function
// - line n uses bit n in every register, lines 0 to 31.
// - after reset lines 0 to 24 are software owned inputs.
// - after reset lines 25 to 31 follow their peripherals.
// - peripheral ports per line: timers 0-8, interrupts 9-12, serial 13-15, 20-22.
// - filter enable, disable, status registers at 0x20/0x24/0x28, status resets zero.
// - output level set, clear, status registers, status resets zero.
// - pin sample register returns synchronised pin levels, not a constant.
// - change status clears at reset, may show changes seen since.
// - owner enable write ones take lines to software, zeros do nothing.
// - software owned line feeds zero to its peripheral input.
// - owner status resets to 0x01FFFFFF.
// - lines without peripheral ignore owner writes and read owned.
// - any level change sets status; interrupt when status and mask set.
// - reading change status clears all its bits except changes landing in the read cycle, which are kept.
module parallel_io_mux_controller #(
    parameter ADDR_W = 8
) (
    input  wire              clk,
    input  wire              srst,
    input  wire [ADDR_W-1:0] reg_addr,
    input  wire [31:0]       reg_wdata,
    input  wire              reg_wr,
    input  wire              reg_rd,
    output reg  [31:0]       reg_rdata,
    input  wire [31:0]       pin_in,
    output reg  [31:0]       pin_out,
    output reg  [31:0]       pin_oe,
    input  wire [31:0]       periph_out,
    input  wire [31:0]       periph_oe,
    output reg  [31:0]       periph_in,
    output reg               change_irq
);

    // ------------------------------------------------------------
    // control registers
    // ------------------------------------------------------------
    reg  [31:0] owner_q;
    reg  [31:0] owner_d;
    reg  [31:0] drive_q;
    reg  [31:0] drive_d;
    reg  [31:0] filter_q;
    reg  [31:0] filter_d;
    reg  [31:0] out_level_q;
    reg  [31:0] out_level_d;
    reg  [31:0] irq_mask_q;
    reg  [31:0] irq_mask_d;
    reg  [31:0] irq_stat_q;
    reg  [31:0] irq_stat_d;
    reg  [31:0] rdata_d;

    // ------------------------------------------------------------
    // pin path state
    // ------------------------------------------------------------
    reg  [31:0] sync1_q;
    reg  [31:0] sync2_q;
    reg  [31:0] level_q;
    reg  [31:0] level_prev_q;
    reg         first_q;
    reg  [31:0] pin_out_d;
    reg  [31:0] pin_oe_d;
    reg  [31:0] periph_in_d;

    // ------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------
    // lines without a peripheral never change owner, whatever is written
    wire [31:0] owner_wr_mask    = ~`LINES_NO_PERIPH;
    wire        wr_hit_owner_en  = reg_wr && reg_addr == `OFS_OWNER_ENABLE;
    wire        wr_hit_owner_dis = reg_wr && reg_addr == `OFS_OWNER_DISABLE;
    wire        wr_hit_drive_en  = reg_wr && reg_addr == `OFS_DRIVE_ENABLE;
    wire        wr_hit_drive_dis = reg_wr && reg_addr == `OFS_DRIVE_DISABLE;
    wire        wr_hit_filt_en   = reg_wr && reg_addr == `OFS_FILTER_ENABLE;
    wire        wr_hit_filt_dis  = reg_wr && reg_addr == `OFS_FILTER_DISABLE;
    wire        wr_hit_out_set   = reg_wr && reg_addr == `OFS_OUT_SET;
    wire        wr_hit_out_clr   = reg_wr && reg_addr == `OFS_OUT_CLEAR;
    wire        wr_hit_irq_en    = reg_wr && reg_addr == `OFS_IRQ_ENABLE;
    wire        wr_hit_irq_dis   = reg_wr && reg_addr == `OFS_IRQ_DISABLE;

    // ------------------------------------------------------------
    // read decode
    // ------------------------------------------------------------
    wire        rd_irq_stat      = reg_rd && reg_addr == `OFS_IRQ_STATUS;
    wire [31:0] changed          = level_q ^ level_prev_q;

    // ------------------------------------------------------------
    // status views
    // ------------------------------------------------------------
    // plain lines always read as software owned
    wire [31:0] owner_view       = owner_q | `LINES_NO_PERIPH;
    // a change landing in the read cycle is returned and also kept
    wire [31:0] irq_view         = irq_stat_q | (first_q ? `RST_ZERO : changed);

    // ------------------------------------------------------------
    // line ownership
    // ------------------------------------------------------------
    always @* begin
        owner_d = owner_q;
        if (wr_hit_owner_en) begin
            owner_d = owner_q | (reg_wdata & owner_wr_mask);
        end
        if (wr_hit_owner_dis) begin
            owner_d = owner_q & ~(reg_wdata & owner_wr_mask);
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            owner_q <= `RST_OWNER;
        end else begin
            owner_q <= owner_d;
        end
    end

    // ------------------------------------------------------------
    // drive enable
    // ------------------------------------------------------------
    always @* begin
        drive_d = drive_q;
        if (wr_hit_drive_en) begin
            drive_d = drive_q | reg_wdata;
        end
        if (wr_hit_drive_dis) begin
            drive_d = drive_q & ~reg_wdata;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            drive_q <= `RST_ZERO;
        end else begin
            drive_q <= drive_d;
        end
    end

    // ------------------------------------------------------------
    // glitch filter enable
    // ------------------------------------------------------------
    always @* begin
        filter_d = filter_q;
        if (wr_hit_filt_en) begin
            filter_d = filter_q | reg_wdata;
        end
        if (wr_hit_filt_dis) begin
            filter_d = filter_q & ~reg_wdata;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            filter_q <= `RST_ZERO;
        end else begin
            filter_q <= filter_d;
        end
    end

    // ------------------------------------------------------------
    // output level
    // ------------------------------------------------------------
    always @* begin
        out_level_d = out_level_q;
        if (wr_hit_out_set) begin
            out_level_d = out_level_q | reg_wdata;
        end
        if (wr_hit_out_clr) begin
            out_level_d = out_level_q & ~reg_wdata;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            out_level_q <= `RST_ZERO;
        end else begin
            out_level_q <= out_level_d;
        end
    end

    // ------------------------------------------------------------
    // change interrupt mask
    // ------------------------------------------------------------
    always @* begin
        irq_mask_d = irq_mask_q;
        if (wr_hit_irq_en) begin
            irq_mask_d = irq_mask_q | reg_wdata;
        end
        if (wr_hit_irq_dis) begin
            irq_mask_d = irq_mask_q & ~reg_wdata;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            irq_mask_q <= `RST_ZERO;
        end else begin
            irq_mask_q <= irq_mask_d;
        end
    end

    // ------------------------------------------------------------
    // pin synchroniser and glitch filter
    // ------------------------------------------------------------
    // the filter passes a level that held for FILTER_CYCLES+1 samples, or at once if it reverses the level passed one sample earlier,
    // trading FILTER_CYCLES cycles of latency for immunity to single-cycle spikes except in the sample right after a passed change
    // two flops before any logic looks at the pins
    always @(posedge clk) begin
        sync1_q <= pin_in;
        sync2_q <= sync1_q;
    end

    genvar gi;
    generate
        for (gi = 0; gi < 32; gi = gi + 1) begin : g_filt
            reg  [1:0] cnt_q;
            wire       raw_bit = sync2_q[gi];
            wire       differs = raw_bit != level_q[gi];
            wire       settled = cnt_q == `FILTER_CYCLES;
            always @(posedge clk) begin
                if (srst) begin
                    cnt_q <= 2'h0;
                end else if (!differs) begin
                    cnt_q <= 2'h0;
                end else if (!settled) begin
                    cnt_q <= cnt_q + 2'h1;
                end
            end
            // reset loads the pin level so leaving reset is not a change
            always @(posedge clk) begin
                if (srst) begin
                    level_q[gi] <= raw_bit;
                end else if (!filter_q[gi] || settled) begin
                    level_q[gi] <= raw_bit;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // change detection
    // ------------------------------------------------------------
    // reset copies the level so leaving reset itself is no change
    always @(posedge clk) begin
        if (srst) begin
            first_q      <= 1'b1;
            level_prev_q <= level_q;
        end else begin
            first_q      <= 1'b0;
            level_prev_q <= level_q;
        end
    end

    // ------------------------------------------------------------
    // change status: set wins over the read clear
    // ------------------------------------------------------------
    always @* begin
        irq_stat_d = irq_stat_q;
        if (rd_irq_stat) begin
            irq_stat_d = `RST_ZERO;
        end
        if (!first_q) begin
            irq_stat_d = irq_stat_d | changed;
        end
    end

    always @(posedge clk) begin
        if (srst) begin
            irq_stat_q <= `RST_ZERO;
        end else begin
            irq_stat_q <= irq_stat_d;
        end
    end

    // ------------------------------------------------------------
    // change interrupt output
    // ------------------------------------------------------------
    // uses the next status so a read clear drops the line without lag
    always @(posedge clk) begin
        if (srst) begin
            change_irq <= 1'b0;
        end else begin
            change_irq <= |(irq_stat_d & irq_mask_q);
        end
    end

    // ------------------------------------------------------------
    // pin and peripheral multiplexing
    // ------------------------------------------------------------
    // peripheral numbering by line is fixed by wiring of periph_* ports
    always @* begin
        pin_out_d = (owner_q & out_level_q) | (~owner_q & periph_out);
        pin_oe_d  = (owner_q & drive_q) | (~owner_q & periph_oe & owner_wr_mask);
    end

    always @(posedge clk) begin
        if (srst) begin
            pin_out <= `RST_ZERO;
            pin_oe  <= `RST_ZERO;
        end else begin
            pin_out <= pin_out_d;
            pin_oe  <= pin_oe_d;
        end
    end

    // ------------------------------------------------------------
    // peripheral input multiplexing
    // ------------------------------------------------------------
    // a software owned or plain line shows zero to the peripheral side
    always @* begin
        periph_in_d = level_q & ~owner_q & owner_wr_mask;
    end

    always @(posedge clk) begin
        if (srst) begin
            periph_in <= `RST_ZERO;
        end else begin
            periph_in <= periph_in_d;
        end
    end

    // ------------------------------------------------------------
    // register read
    // ------------------------------------------------------------
    always @* begin
        rdata_d = `RST_ZERO;
        case (reg_addr)
            `OFS_OWNER_STATUS: begin
                rdata_d = owner_view;
            end
            `OFS_DRIVE_STATUS: begin
                rdata_d = drive_q;
            end
            `OFS_FILTER_STATUS: begin
                rdata_d = filter_q;
            end
            `OFS_OUT_STATUS: begin
                rdata_d = out_level_q;
            end
            `OFS_PIN_SAMPLE: begin
                rdata_d = level_q;
            end
            `OFS_IRQ_MASK: begin
                rdata_d = irq_mask_q;
            end
            `OFS_IRQ_STATUS: begin
                rdata_d = irq_view;
            end
            // write-only words give nothing back
            `OFS_OWNER_ENABLE,
            `OFS_OWNER_DISABLE,
            `OFS_DRIVE_ENABLE,
            `OFS_DRIVE_DISABLE,
            `OFS_FILTER_ENABLE,
            `OFS_FILTER_DISABLE,
            `OFS_OUT_SET,
            `OFS_OUT_CLEAR,
            `OFS_IRQ_ENABLE,
            `OFS_IRQ_DISABLE: begin
                rdata_d = `RST_ZERO;
            end
            `OFS_RESV_0, `OFS_RESV_1, `OFS_RESV_2: begin
                rdata_d = `RST_ZERO;
            end
            default: begin
                rdata_d = `RST_ZERO;
            end
        endcase
    end

    // read data stands only in the cycle after the strobe
    always @(posedge clk) begin
        if (srst) begin
            reg_rdata <= `RST_ZERO;
        end else if (reg_rd) begin
            reg_rdata <= rdata_d;
        end else begin
            reg_rdata <= `RST_ZERO;
        end
    end

endmodule

// ==== test/parallel_io_mux_controller_bench.sv ====
`timescale 1ns/1ps
`define CHK(nm, e, s) begin n_tests++; if ((s) !== (e)) begin bad_count++; \
    $display("ERROR %s expected %h seen %h", nm, e, s); end end
// ----------------------------------------
// register scenarios
// ----------------------------------------
module parallel_io_mux_controller_bench;
    logic        clk = 1'b0;
    logic        srst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [31:0] ext_level = 32'h0;
    wire  [31:0] reg_rdata, pin_in, pin_out, pin_oe, periph_out, periph_oe, periph_in;
    wire         change_irq;
    int          bad_count = 0;
    int          n_tests = 0;
    parallel_io_mux_controller dut (.*);
    pin_side_model pins (.*);
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_rd <= 1'b0;
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m = '1);
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 `CHK("reg_rdata", e, reg_rdata & m)
    endtask
    // strobes drop on the first edge so a pending write is one cycle only
    task automatic wt(input int n);
        repeat (n) @(posedge clk) begin
            reg_wr <= 1'b0;
            reg_rd <= 1'b0;
        end
        #1;
    endtask
    task automatic tally_and_finish;
        if (bad_count == 0 && n_tests > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial forever #2.5 clk = ~clk;
    initial begin
        #20000;
        bad_count++;
        tally_and_finish;
    end
    initial begin
        repeat (4) @(posedge clk);
        srst <= 1'b0;
        wt(4);
        `CHK("pin_oe", 32'hFE000000, pin_oe)
        `CHK("pin_out", 32'hA4000000, pin_out)
        rd(8'h08, 32'h01FFFFFF);
        rd(8'h18, 32'h0);
        rd(8'h28, 32'h0);
        rd(8'h38, 32'h0);
        rd(8'h48, 32'h0);
        rd(8'h0C, 32'h0);
        rd(8'h00, 32'h0);
        wr(8'h04, 32'hFFFFFFFF);
        rd(8'h08, 32'h018F0000);
        wr(8'h00, 32'h00000001);
        rd(8'h08, 32'h018F0001);
        @(posedge clk) ext_level[9] <= 1'b1;
        wt(10);
        `CHK("periph_in", 32'hA4000200, periph_in)
        wr(8'h00, 32'hFFFFFFFF);
        wt(3);
        `CHK("periph_in", 32'h0, periph_in)
        rd(8'h08, 32'hFFFFFFFF);
        wr(8'h10, 32'h1);
        wr(8'h30, 32'h1);
        rd(8'h38, 32'h1);
        rd(8'h18, 32'h1);
        wt(2);
        `CHK("pin_out", 32'h1, pin_out)
        `CHK("pin_oe", 32'h1, pin_oe)
        wr(8'h34, 32'h1);
        rd(8'h38, 32'h0);
        wr(8'h20, 32'hF);
        wr(8'h24, 32'h5);
        rd(8'h28, 32'hA);
        @(posedge clk) ext_level <= 32'h12345678;
        wr(8'h14, 32'hFFFFFFFF);
        wt(12);
        rd(8'h3C, 32'h12345678);
        rd(8'h4C, 32'hB6345679);
        @(posedge clk) ext_level[4] <= 1'b0;
        wr(8'h40, 32'h10);
        wt(10);
        `CHK("change_irq", 1'b1, change_irq)
        rd(8'h4C, 32'h10);
        rd(8'h4C, 32'h0);
        wt(1);
        `CHK("change_irq", 1'b0, change_irq)
        wr(8'h44, 32'hFFFFFFFF);
        wt(3);
        rd(8'h48, 32'h0);
        tally_and_finish;
    end
endmodule

// ==== test/parallel_io_mux_controller_chk.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// register port and output relations
// ----------------------------------------
module line_port_chk #(parameter ADDR_W = 8) (
    input wire              clk,
    input wire              srst,
    input wire [ADDR_W-1:0] reg_addr,
    input wire [31:0]       reg_wdata,
    input wire              reg_wr,
    input wire              reg_rd,
    input wire [31:0]       reg_rdata,
    input wire [31:0]       periph_in,
    input wire              change_irq
);
    default clocking @(posedge clk); endclocking
    default disable iff (srst);
    property p_rd_idle; !$past(reg_rd) |-> reg_rdata == 32'h0; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
    property p_resv; reg_rd && reg_addr == 8'h0C |=> reg_rdata == 32'h0; endproperty
    a_resv: assert property (p_resv) else $error("reserved read not zero");
    property p_no_fn; (periph_in & 32'h018F0000) == 32'h0; endproperty
    a_no_fn: assert property (p_no_fn) else $error("unused line reaches peripheral");
    property p_fixed; reg_rd && reg_addr == 8'h08 |=> &(reg_rdata | ~32'h018F0000); endproperty
    a_fixed: assert property (p_fixed) else $error("fixed line not owned");
    property p_own_zero;
        reg_wr && reg_addr == 8'h00 |-> ##3 (periph_in & $past(reg_wdata, 3)) == 32'h0;
    endproperty
    a_own_zero: assert property (p_own_zero) else $error("owned line reaches peripheral");
    property p_irq_off;
        reg_wr && reg_addr == 8'h44 && &reg_wdata ##1 !(reg_wr && reg_addr == 8'h40)
            |-> ##1 !change_irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("masked interrupt stays up");
    property p_set_rd;
        reg_wr && reg_addr == 8'h30 ##1 reg_rd && reg_addr == 8'h38
            |=> &(reg_rdata | ~$past(reg_wdata, 2));
    endproperty
    a_set_rd: assert property (p_set_rd) else $error("set level not read back");
    property p_flt_rd;
        reg_wr && reg_addr == 8'h24 ##1 reg_rd && reg_addr == 8'h28
            |=> (reg_rdata & $past(reg_wdata, 2)) == 32'h0;
    endproperty
    a_flt_rd: assert property (p_flt_rd) else $error("filter not disabled");
endmodule

bind parallel_io_mux_controller line_port_chk #(.ADDR_W(ADDR_W)) chk (.*);

// ==== test/pin_side_model.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// pins and peripherals around the block
// ----------------------------------------
module pin_side_model (
    input  wire [31:0] ext_level,
    input  wire [31:0] pin_out,
    input  wire [31:0] pin_oe,
    output wire [31:0] pin_in,
    output wire [31:0] periph_out,
    output wire [31:0] periph_oe
);
    // an undriven line shows the external circuit, never a stale drive value
    assign pin_in     = (pin_out & pin_oe) | (ext_level & ~pin_oe);
    // only the bus-side lines 25..31 are driven by their peripherals here
    assign periph_oe  = 32'hFE000000;
    assign periph_out = 32'hA4000000;
endmodule
